// ---- src/aiods_map.vh ----
`ifndef AIODS_MAP_VH
`define AIODS_MAP_VH

// Host window placement
`define AIODS_WIN_BASE      10'h300
`define AIODS_SEL_BASE      10'h200
`define AIODS_SLOT_LSB      5
`define AIODS_SLOT_W        2

// Window offset split (address bits 4:3)
`define AIODS_OFF_MSB       4
`define AIODS_OFF_LSB       3
`define AIODS_OFF_REGS_A    2'h0
`define AIODS_OFF_REGS_B    2'h1
`define AIODS_OFF_DATA      2'h2
`define AIODS_OFF_RESET     2'h3
`define AIODS_REG_AW        4

// Board and chip select register fields
`define AIODS_SEL_W         3
`define AIODS_SEL_STEER     2
`define AIODS_SEL_BRD_MSB   1
`define AIODS_SEL_BRD_LSB   0
`define AIODS_SEL_RESET     3'h4

// Data widths
`define AIODS_REP_DW        4
`define AIODS_CTL_DW        8
`define AIODS_PORT_DW       16
`define AIODS_BYTE_W        8
`define AIODS_RAM_AW        14

// Boot ROM decode: host address bits 19:14
`define AIODS_ROM_MSB       19
`define AIODS_ROM_LSB       14
`define AIODS_ROM_SEG       6'h30

// Repeater wait timing
`define AIODS_WAIT_NS       400
`define AIODS_CLK_PS        10000
`define AIODS_WAIT_STEPS    8

`endif

// ---- src/aiods_sync.v ----
`timescale 1ns/1ps
// Three-stage pin synchroniser, output moves when stages two and three agree
module aiods_sync #(
    parameter W = 1
) (
    // Clock and reset
    input  wire         clk_sys,
    input  wire         rst_n,
    // Pins and filtered result
    input  wire [W-1:0] pin_in,
    output reg  [W-1:0] sync_q
);

    reg [W-1:0] s1_q;
    reg [W-1:0] s2_q;
    reg [W-1:0] s3_q;

    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            always @(posedge clk_sys) begin
                if (!rst_n) begin
                    s1_q[i]   <= 1'b1;
                    s2_q[i]   <= 1'b1;
                    s3_q[i]   <= 1'b1;
                    sync_q[i] <= 1'b1;
                end else begin
                    s1_q[i] <= pin_in[i];
                    s2_q[i] <= s1_q[i];
                    s3_q[i] <= s2_q[i];
                    if (s2_q[i] == s3_q[i]) begin
                        sync_q[i] <= s3_q[i];
                    end
                end
            end
        end
    endgenerate

endmodule // aiods_sync

// ---- src/aiods_wait.v ----
`timescale 1ns/1ps
`include "aiods_map.vh"
// Repeater wait timer: prescaler enable plus a 3-bit step counter
module aiods_wait #(
    parameter integer WAIT_NS = `AIODS_WAIT_NS
) (
    // Clock and reset
    input  wire clk_sys,
    input  wire rst_n,
    // Control
    input  wire run,
    output reg  done_q
);

    localparam integer WAIT_CYC = (WAIT_NS * 1000 + `AIODS_CLK_PS - 1) / `AIODS_CLK_PS;
    localparam integer DIV_RAW  = (WAIT_CYC + `AIODS_WAIT_STEPS - 1) / `AIODS_WAIT_STEPS;
    localparam integer DIV      = (DIV_RAW < 1) ? 1 : DIV_RAW;
    localparam integer DIV_M1   = DIV - 1;
    localparam integer STEP_M1  = `AIODS_WAIT_STEPS - 1;
    localparam [7:0]   DIV_LAST = DIV_M1[7:0];
    localparam [2:0]   STEP_END = STEP_M1[2:0];

    reg  [7:0] div_q;
    reg  [2:0] step_q;
    wire       tick = run && (div_q == DIV_LAST);

    always @(posedge clk_sys) begin
        if (!rst_n || !run) begin
            div_q  <= 8'h00;
            step_q <= 3'h0;
            done_q <= 1'b0;
        end else begin
            div_q <= tick ? 8'h00 : div_q + 8'h01;
            if (tick && !done_q) begin
                step_q <= step_q + 3'h1;
                if (step_q == STEP_END) begin
                    done_q <= 1'b1;
                end
            end
        end
    end

endmodule // aiods_wait

// ---- src/aiods_top.v ----
`timescale 1ns/1ps
`include "aiods_map.vh"
module aiods_top #(
    parameter integer WAIT_NS  = `AIODS_WAIT_NS,
    parameter [5:0]   ROM_SEG  = `AIODS_ROM_SEG,
    parameter         RAM_BIT  = 1'b1
) (
    // Clock and reset
    input  wire                       clk_sys,
    input  wire                       rst_n,
    // Host bus pins
    input  wire [19:0]                host_addr,
    input  wire                       host_rd_n,
    input  wire                       host_wr_n,
    input  wire                       host_ack_n,
    input  wire                       system_memory_read_n,
    input  wire [15:0]                host_data_in,
    output reg  [15:0]                host_data_out_q,
    output reg                        host_data_oe_n_q,
    output reg                        host_rdy_out_q,
    output reg                        host_rdy_oe_n_q,
    // Jumpers and board position
    input  wire                       window_jumper_a,
    input  wire                       window_jumper_b,
    input  wire                       select_reg_jumper_a,
    input  wire                       select_reg_jumper_b,
    input  wire [1:0]                 board_position,
    // Chip register side
    output reg  [`AIODS_REG_AW-1:0]   reg_addr_q,
    output reg                        reg_rd_n_q,
    output reg                        reg_wr_n_q,
    output reg  [`AIODS_CTL_DW-1:0]   reg_wdata_q,
    output reg                        repeater_chip_cs_n_q,
    output reg                        network_controller_cs_n_q,
    input  wire                       repeater_chip_bus_en_n,
    input  wire [`AIODS_REP_DW-1:0]   repeater_chip_rdata,
    input  wire [`AIODS_CTL_DW-1:0]   network_controller_rdata,
    // Packet data latches
    output reg  [`AIODS_PORT_DW-1:0]  to_mem_data_q,
    output reg                        to_mem_load_q,
    input  wire [`AIODS_PORT_DW-1:0]  to_host_data,
    input  wire                       to_host_load,
    input  wire                       prom_read,
    // Controller local bus
    input  wire [`AIODS_RAM_AW:0]     local_addr,
    input  wire                       local_rd,
    output reg  [`AIODS_RAM_AW-1:0]   ram_addr_q,
    output reg                        ram_sel_n_q,
    output reg                        prom_sel_n_q,
    // Misc
    output reg                        boot_rom_enable_n_q,
    output reg                        reset_port_q,
    output reg  [`AIODS_SEL_W-1:0]    board_and_chip_select_q
);

    // Repeater access: idle, count the wait, hold until the strobe ends
    localparam [2:0] ST_IDLE = 3'h1;
    localparam [2:0] ST_WAIT = 3'h2;
    localparam [2:0] ST_HOLD = 3'h4;

    // Synchronised pins
    wire [19:0] sa;
    wire [15:0] sd;
    wire        rd_n;
    wire        wr_n;
    wire        ack_n;
    wire        memr_n;
    wire        busen_n;
    wire [5:0]  jmp;

    aiods_sync #(.W(20)) u_sync_addr (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .pin_in  (host_addr),
        .sync_q  (sa)
    );

    aiods_sync #(.W(16)) u_sync_data (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .pin_in  (host_data_in),
        .sync_q  (sd)
    );

    aiods_sync #(.W(11)) u_sync_ctl (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .pin_in  ({host_rd_n, host_wr_n, host_ack_n, system_memory_read_n,
                   repeater_chip_bus_en_n, window_jumper_a, window_jumper_b,
                   select_reg_jumper_a, select_reg_jumper_b, board_position}),
        .sync_q  ({rd_n, wr_n, ack_n, memr_n, busen_n, jmp})
    );

    // Jumper ON reads as one; slot index bits mark OFF jumpers, jumper B as the high bit
    wire [1:0] win_slot = {~jmp[4], ~jmp[5]};
    wire [1:0] sel_slot = {~jmp[2], ~jmp[3]};
    wire [1:0] own_pos  = jmp[1:0];

    // Window and select bases built from the jumper slots
    wire [9:0] win_base = `AIODS_WIN_BASE | ({8'h00, win_slot} << `AIODS_SLOT_LSB);
    wire [9:0] sel_base = `AIODS_SEL_BASE | ({8'h00, sel_slot} << `AIODS_SLOT_LSB);

    // DMA acknowledge cycles never decode as I/O
    wire io_ok   = ack_n;
    wire win_hit = io_ok && (sa[9:5] == win_base[9:5]);
    wire sel_hit = io_ok && (sa[9:0] == sel_base);
    wire [1:0] off = sa[`AIODS_OFF_MSB:`AIODS_OFF_LSB];
    wire reg_hit  = win_hit && (off == `AIODS_OFF_REGS_A || off == `AIODS_OFF_REGS_B);
    wire data_hit = win_hit && (off == `AIODS_OFF_DATA);
    wire rst_hit  = win_hit && (off == `AIODS_OFF_RESET);

    wire to_ctl   = board_and_chip_select_q[`AIODS_SEL_STEER];
    wire brd_ok   = (board_and_chip_select_q[`AIODS_SEL_BRD_MSB:`AIODS_SEL_BRD_LSB]
                     == own_pos);
    wire strobe   = !rd_n || !wr_n;

    reg  [2:0]  st_q;
    reg  [2:0]  st_d;
    reg         wr_prev_q;
    reg         strobe_prev_q;
    reg         sel_arm_q;
    reg  [2:0]  sel_data_q;
    reg  [15:0] to_host_q;
    reg         wait_run_q;
    wire        wait_done;

    // Timer restarts from zero whenever its run request drops
    aiods_wait #(.WAIT_NS(WAIT_NS)) u_wait (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .run     (wait_run_q),
        .done_q  (wait_done)
    );

    // Matching repeater access; a board whose number differs stays silent
    wire rep_go = reg_hit && !to_ctl && brd_ok && strobe;
    // Controller sees register and data port accesses while steered to it
    wire ctl_go = (reg_hit || data_hit) && to_ctl && strobe;
    // Ready stays pulled false for the whole counting phase
    wire rdy_hold = (st_d == ST_WAIT);

    // Repeater access sequence
    always @* begin
        st_d = st_q;
        case (st_q)
            ST_IDLE: begin
                if (rep_go) begin
                    st_d = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (!strobe) begin
                    st_d = ST_IDLE;
                end else if (wait_done) begin
                    st_d = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (!strobe) begin
                    st_d = ST_IDLE;
                end
            end
            default: begin
                st_d = ST_IDLE;
            end
        endcase
    end

    always @(posedge clk_sys) begin
        if (!rst_n) begin
            st_q       <= ST_IDLE;
            wait_run_q <= 1'b0;
        end else begin
            st_q       <= st_d;
            // Count starts once the repeater opens its buffer
            wait_run_q <= (st_d == ST_WAIT) && !busen_n;
        end
    end

    // Select register: arm while written, commit on the strobe rising edge
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            board_and_chip_select_q <= `AIODS_SEL_RESET;
            wr_prev_q               <= 1'b1;
            sel_arm_q               <= 1'b0;
            sel_data_q              <= 3'h0;
        end else begin
            wr_prev_q <= wr_n;
            // Last low cycle decides both the hit and the data
            if (!wr_n) begin
                sel_arm_q  <= sel_hit;
                sel_data_q <= sd[`AIODS_SEL_W-1:0];
            end
            if (wr_n && !wr_prev_q && sel_arm_q) begin
                board_and_chip_select_q <= sel_data_q;
                sel_arm_q               <= 1'b0;
            end
        end
    end

    // Chip register strobes and selects
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            reg_addr_q                <= 4'h0;
            reg_rd_n_q                <= 1'b1;
            reg_wr_n_q                <= 1'b1;
            reg_wdata_q               <= 8'h00;
            repeater_chip_cs_n_q      <= 1'b1;
            network_controller_cs_n_q <= 1'b1;
            host_rdy_out_q            <= 1'b0;
            host_rdy_oe_n_q           <= 1'b1;
        end else begin
            reg_addr_q  <= sa[`AIODS_REG_AW-1:0];
            reg_rd_n_q  <= !(reg_hit && !rd_n);
            reg_wr_n_q  <= !(reg_hit && !wr_n);
            reg_wdata_q <= sd[`AIODS_CTL_DW-1:0];
            // Chip strobes follow the window decode; selects add steering, and board match for the repeater select only
            repeater_chip_cs_n_q      <= !rep_go;
            network_controller_cs_n_q <= !ctl_go;
            // Open-drain ready: pulled low only while waiting
            host_rdy_out_q  <= 1'b0;
            host_rdy_oe_n_q <= !rdy_hold;
        end
    end

    // Host read data and packet data latches
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            to_host_q        <= 16'h0000;
            to_mem_data_q    <= 16'h0000;
            to_mem_load_q    <= 1'b0;
            host_data_out_q  <= 16'h0000;
            host_data_oe_n_q <= 1'b1;
            strobe_prev_q    <= 1'b0;
        end else begin
            strobe_prev_q <= strobe;
            if (to_host_load) begin
                to_host_q <= to_host_data;
            end
            to_mem_load_q <= 1'b0;
            if (data_hit && wr_n && !wr_prev_q) begin
                to_mem_data_q <= sd;
                to_mem_load_q <= 1'b1;
            end
            host_data_oe_n_q <= 1'b1;
            host_data_out_q  <= 16'h0000;
            // Select register reads fall through: it is write only
            if (!rd_n && data_hit) begin
                // Only to_host_q drives, all 16 bits; PROM data only in low byte
                host_data_oe_n_q <= 1'b0;
                host_data_out_q  <= prom_read ? {8'h00, to_host_q[`AIODS_BYTE_W-1:0]}
                                              : to_host_q;
            end else if (!rd_n && reg_hit && to_ctl) begin
                host_data_oe_n_q <= 1'b0;
                host_data_out_q  <= {8'h00, network_controller_rdata};
            end else if (!rd_n && reg_hit && brd_ok) begin
                host_data_oe_n_q <= 1'b0;
                host_data_out_q  <= {12'h000, repeater_chip_rdata};
            end
        end
    end

    // Reset port, boot ROM and local memory selects
    always @(posedge clk_sys) begin
        if (!rst_n) begin
            reset_port_q        <= 1'b0;
            boot_rom_enable_n_q <= 1'b1;
            ram_addr_q          <= 14'h0000;
            ram_sel_n_q         <= 1'b1;
            prom_sel_n_q        <= 1'b1;
        end else begin
            // One pulse per strobe, however long the strobe stays low
            reset_port_q        <= rst_hit && strobe && !strobe_prev_q;
            boot_rom_enable_n_q <= !(!memr_n &&
                                     sa[`AIODS_ROM_MSB:`AIODS_ROM_LSB] == ROM_SEG);
            ram_addr_q   <= local_addr[`AIODS_RAM_AW-1:0];
            ram_sel_n_q  <= !(local_rd && local_addr[`AIODS_RAM_AW] == RAM_BIT);
            prom_sel_n_q <= !(local_rd && local_addr[`AIODS_RAM_AW] != RAM_BIT);
        end
    end

endmodule // aiods_top

// ---- dv/aiods_assertions.sv ----
`timescale 1ns/1ps
module aiods_assertions (
    // Clock and reset
    input wire       clk_sys,
    input wire       rst_n,
    // Watched ports
    input wire [1:0] board_position,
    input wire       host_rdy_out_q,
    input wire       host_rdy_oe_n_q,
    input wire       repeater_chip_cs_n_q,
    input wire       network_controller_cs_n_q,
    input wire       ram_sel_n_q,
    input wire       prom_sel_n_q,
    input wire       reset_port_q,
    input wire       to_mem_load_q,
    input wire [2:0] board_and_chip_select_q
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    // Consecutive cycles with ready pulled false
    reg [7:0] rdy_low_q;
    always @(posedge clk_sys) begin
        if (!rst_n || host_rdy_oe_n_q)
            rdy_low_q <= 8'h00;
        else if (rdy_low_q != 8'hff)
            rdy_low_q <= rdy_low_q + 8'h01;
    end
    a_sel_reset_value: assert property (disable iff (1'b0) !rst_n |=> board_and_chip_select_q == 3'h4)
        else $error("select register wrong after reset");
    a_chip_sel_excl: assert property (!(!repeater_chip_cs_n_q && !network_controller_cs_n_q))
        else $error("both chip selects low");
    a_ctl_needs_steer: assert property (!network_controller_cs_n_q |-> board_and_chip_select_q[2])
        else $error("controller selected with steer bit zero");
    a_rep_board_match: assert property (!repeater_chip_cs_n_q |-> board_and_chip_select_q == {1'b0, board_position})
        else $error("repeater selected without match");
    a_rdy_drive_low: assert property (host_rdy_out_q == 1'b0)
        else $error("ready line driven high");
    a_rdy_with_rep: assert property (!host_rdy_oe_n_q |-> !repeater_chip_cs_n_q)
        else $error("ready held outside repeater access");
    a_rdy_wait_bound: assert property ($rose(host_rdy_oe_n_q) |-> rdy_low_q >= 8'h28 && rdy_low_q <= 8'h64)
        else $error("ready hold length wrong");
    a_rdy_hold_cap: assert property (rdy_low_q <= 8'h64)
        else $error("ready held false too long");
    a_local_sel_excl: assert property (!ram_sel_n_q |-> prom_sel_n_q)
        else $error("ram and prom selected together");
    a_reset_one_pulse: assert property (reset_port_q |=> !reset_port_q)
        else $error("reset port pulse too long");
    a_load_one_pulse: assert property ($rose(to_mem_load_q) |=> $fell(to_mem_load_q))
        else $error("load pulse too long");
endmodule // aiods_assertions

bind aiods_top aiods_assertions u_chk (
    .clk_sys(clk_sys), .rst_n(rst_n), .board_position(board_position), .host_rdy_out_q(host_rdy_out_q),
    .host_rdy_oe_n_q(host_rdy_oe_n_q), .repeater_chip_cs_n_q(repeater_chip_cs_n_q),
    .network_controller_cs_n_q(network_controller_cs_n_q), .ram_sel_n_q(ram_sel_n_q), .prom_sel_n_q(prom_sel_n_q),
    .reset_port_q(reset_port_q), .to_mem_load_q(to_mem_load_q), .board_and_chip_select_q(board_and_chip_select_q)
);

// ---- dv/aiods_chips.sv ----
`timescale 1ns/1ps
module aiods_chips (
    // Clock and answer speed
    input  wire       clk_sys,
    input  wire [3:0] delay,
    // Chip register side
    input  wire [3:0] reg_addr_q,
    input  wire       reg_rd_n_q,
    input  wire       reg_wr_n_q,
    input  wire [7:0] reg_wdata_q,
    input  wire       repeater_chip_cs_n_q,
    input  wire       network_controller_cs_n_q,
    output reg        repeater_chip_bus_en_n = 1'b1,
    output reg  [3:0] repeater_chip_rdata = 4'h0,
    output reg  [7:0] network_controller_rdata = 8'h0
);
    reg [3:0] rep_m [0:15];
    reg [7:0] ctl_m [0:15];
    integer   cnt = 0;
    always @(posedge clk_sys) begin
        cnt <= (!repeater_chip_cs_n_q && !(reg_rd_n_q && reg_wr_n_q)) ? cnt + 1 : 0;
        repeater_chip_bus_en_n <= !(cnt > delay);
        if (!repeater_chip_cs_n_q && !reg_wr_n_q) begin
            rep_m[reg_addr_q] <= reg_wdata_q[3:0];
        end
        if (!network_controller_cs_n_q && !reg_wr_n_q) begin
            ctl_m[reg_addr_q] <= reg_wdata_q;
        end
        // Released lines show the inverse of the last value
        repeater_chip_rdata <= (!repeater_chip_cs_n_q && !reg_rd_n_q) ? rep_m[reg_addr_q] : ~repeater_chip_rdata;
        network_controller_rdata <= (!network_controller_cs_n_q && !reg_rd_n_q) ? ctl_m[reg_addr_q]
                                    : ~network_controller_rdata;
    end
endmodule // aiods_chips

// ---- dv/adapter_io_decode_select_bench.sv ----
`timescale 1ns/1ps
module adapter_io_decode_select_bench;
    reg         clk_sys = 1'b0;
    reg         rst_n, host_rd_n, host_wr_n, host_ack_n, system_memory_read_n, to_host_load, prom_read, local_rd;
    reg         window_jumper_a, window_jumper_b, select_reg_jumper_a, select_reg_jumper_b, rep_seen, oe_seen;
    reg  [19:0] host_addr;
    reg  [15:0] host_data_in, to_host_data, last_mem, q, v, w;
    reg  [14:0] local_addr;
    reg  [1:0]  board_position;
    reg  [3:0]  delay, k;
    reg  [9:0]  wb, sb;
    reg  [31:0] seed = 32'h34e1;
    wire [15:0] host_data_out_q, to_mem_data_q;
    wire        host_data_oe_n_q, host_rdy_out_q, host_rdy_oe_n_q, reg_rd_n_q, reg_wr_n_q, reset_port_q;
    wire        repeater_chip_cs_n_q, network_controller_cs_n_q, to_mem_load_q, ram_sel_n_q, prom_sel_n_q;
    wire        boot_rom_enable_n_q, repeater_chip_bus_en_n;
    wire [3:0]  reg_addr_q, repeater_chip_rdata;
    wire [7:0]  reg_wdata_q, network_controller_rdata;
    wire [13:0] ram_addr_q;
    wire [2:0]  board_and_chip_select_q;
    integer     fails = 0, n_compared = 0, cyc = 0, n_rst = 0, n0, i;
    integer     ctl_m [0:15];
    integer     rep_m [0:15];

    aiods_top dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .host_addr(host_addr), .host_rd_n(host_rd_n), .host_wr_n(host_wr_n),
        .host_ack_n(host_ack_n), .system_memory_read_n(system_memory_read_n), .host_data_in(host_data_in),
        .host_data_out_q(host_data_out_q), .host_data_oe_n_q(host_data_oe_n_q), .host_rdy_out_q(host_rdy_out_q),
        .host_rdy_oe_n_q(host_rdy_oe_n_q), .window_jumper_a(window_jumper_a), .window_jumper_b(window_jumper_b),
        .select_reg_jumper_a(select_reg_jumper_a), .select_reg_jumper_b(select_reg_jumper_b),
        .board_position(board_position), .reg_addr_q(reg_addr_q), .reg_rd_n_q(reg_rd_n_q), .reg_wr_n_q(reg_wr_n_q),
        .reg_wdata_q(reg_wdata_q), .repeater_chip_cs_n_q(repeater_chip_cs_n_q),
        .network_controller_cs_n_q(network_controller_cs_n_q), .repeater_chip_bus_en_n(repeater_chip_bus_en_n),
        .repeater_chip_rdata(repeater_chip_rdata), .network_controller_rdata(network_controller_rdata),
        .to_mem_data_q(to_mem_data_q), .to_mem_load_q(to_mem_load_q), .to_host_data(to_host_data),
        .to_host_load(to_host_load), .prom_read(prom_read), .local_addr(local_addr), .local_rd(local_rd),
        .ram_addr_q(ram_addr_q), .ram_sel_n_q(ram_sel_n_q), .prom_sel_n_q(prom_sel_n_q),
        .boot_rom_enable_n_q(boot_rom_enable_n_q), .reset_port_q(reset_port_q),
        .board_and_chip_select_q(board_and_chip_select_q));
    aiods_chips chips (
        .clk_sys(clk_sys), .delay(delay), .reg_addr_q(reg_addr_q), .reg_rd_n_q(reg_rd_n_q), .reg_wr_n_q(reg_wr_n_q),
        .reg_wdata_q(reg_wdata_q), .repeater_chip_cs_n_q(repeater_chip_cs_n_q),
        .network_controller_cs_n_q(network_controller_cs_n_q), .repeater_chip_bus_en_n(repeater_chip_bus_en_n),
        .repeater_chip_rdata(repeater_chip_rdata), .network_controller_rdata(network_controller_rdata));

    always #5 clk_sys = ~clk_sys;

    function [15:0] rnd;
        input dummy;
        begin
            seed = seed ^ (seed << 13);
            seed = seed ^ (seed >> 17);
            seed = seed ^ (seed << 5);
            rnd = seed[15:0];
        end
    endfunction

    task summarize;
        begin
            $display("compared %0d mismatches %0d", n_compared, fails);
            if (fails == 0 && n_compared > 0)
                $display("No errors found");
            else
                $display("Errors were found");
            $finish;
        end
    endtask

    task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        begin
            n_compared = n_compared + 1;
            if (g !== e) begin
                fails = fails + 1;
                $display("BAD %s expected %h seen %h", nm, e, g);
            end
        end
    endtask

    // One host I/O cycle; waits out a held ready line, samples data before release
    task io(input bit wr, input [9:0] a, input [15:0] d);
        integer n;
        begin
            n = 0;
            @(posedge clk_sys);
            host_addr <= {10'h0, a};
            host_data_in <= d;
            host_wr_n <= !wr;
            host_rd_n <= wr;
            repeat (12) @(posedge clk_sys);
            while (host_rdy_oe_n_q !== 1'b1 && n < 200) begin
                @(posedge clk_sys);
                n = n + 1;
            end
            chk("ready_release", 16'h1, {15'h0, host_rdy_oe_n_q});
            q = host_data_out_q;
            host_wr_n <= 1'b1;
            host_rd_n <= 1'b1;
            repeat (8) @(posedge clk_sys);
        end
    endtask

    always @(posedge clk_sys) begin
        cyc = cyc + 1;
        if (reset_port_q === 1'b1)
            n_rst = n_rst + 1;
        if (to_mem_load_q === 1'b1)
            last_mem = to_mem_data_q;
        if (repeater_chip_cs_n_q === 1'b0)
            rep_seen = 1'b1;
        if (host_data_oe_n_q === 1'b0)
            oe_seen = 1'b1;
        if (cyc == 20000) begin
            fails = fails + 1;
            summarize();
        end
    end

    initial begin
        {rst_n, to_host_load, prom_read, local_rd, local_addr, to_host_data, host_addr, host_data_in} = 0;
        {host_rd_n, host_wr_n, host_ack_n, system_memory_read_n} = 4'hf;
        {window_jumper_a, window_jumper_b, select_reg_jumper_a, select_reg_jumper_b} = 4'hf;
        board_position = 2'h0;
        delay = 4'h1;
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (5) @(posedge clk_sys);
        chk("select", 16'h4, board_and_chip_select_q);
        for (i = 0; i < 4; i = i + 1) begin
            {window_jumper_b, window_jumper_a} <= i[1:0];
            {select_reg_jumper_b, select_reg_jumper_a} <= i[1:0];
            board_position <= ~i[1:0];
            delay <= {i[1:0], 2'h0};
            wb = 10'h300 | {3'h0, ~i[1:0], 5'h0};
            sb = 10'h200 | {3'h0, ~i[1:0], 5'h0};
            repeat (8) @(posedge clk_sys);
            v = rnd(0);
            io(1'b1, sb, v);
            chk("select", {13'h0, v[2:0]}, board_and_chip_select_q);
            io(1'b1, sb ^ 10'h20, ~v);
            chk("select", {13'h0, v[2:0]}, board_and_chip_select_q);
            oe_seen = 1'b0;
            io(1'b0, sb, 16'h0);
            chk("select_read_oe", 16'h0, oe_seen);
            io(1'b1, sb, {13'h0, 1'b1, board_position});
            v = rnd(0);
            k = v[3:0];
            w = rnd(0);
            io(1'b1, wb + {6'h0, k}, w);
            ctl_m[k] = w[7:0];
            oe_seen = 1'b0;
            io(1'b0, wb + {6'h0, k}, 16'h0);
            chk("ctl_read", ctl_m[k][15:0], q);
            chk("read_oe", 16'h1, oe_seen);
            io(1'b1, sb, {14'h0, board_position});
            io(1'b1, wb + {6'h0, k}, w);
            rep_m[k] = w[3:0];
            io(1'b0, wb + {6'h0, k}, 16'h0);
            chk("rep_read", rep_m[k][15:0], q);
            io(1'b1, sb, {14'h0, ~board_position});
            rep_seen = 1'b0;
            io(1'b0, wb + {6'h0, k}, 16'h0);
            chk("rep_cs", 16'h0, rep_seen);
            io(1'b1, sb, {13'h0, 1'b1, board_position});
            w = rnd(0);
            io(1'b1, wb + 10'h10, w);
            chk("to_mem", w, last_mem);
            w = rnd(0);
            to_host_data <= w;
            to_host_load <= 1'b1;
            prom_read <= i[0];
            @(posedge clk_sys);
            to_host_load <= 1'b0;
            io(1'b0, wb + 10'h16, 16'h0);
            chk("from_port", i[0] ? {8'h0, w[7:0]} : w, q);
            n0 = n_rst;
            io(1'b1, wb + 10'h18 + {7'h0, k[2:0]}, 16'h0);
            chk("reset_pulses", 16'h1, 16'(n_rst - n0));
            n0 = n_rst;
            io(1'b1, (wb ^ 10'h20) + 10'h18, 16'h0);
            chk("reset_pulses", 16'h0, 16'(n_rst - n0));
            host_ack_n <= 1'b0;
            oe_seen = 1'b0;
            io(1'b0, wb + 10'h10, 16'h0);
            chk("ack_oe", 16'h0, oe_seen);
            host_ack_n <= 1'b1;
            host_addr <= {6'h30 ^ {4'h0, i[1:0]}, 14'h0};
            system_memory_read_n <= 1'b0;
            local_addr <= {i[0], v[13:0]};
            local_rd <= 1'b1;
            repeat (8) @(posedge clk_sys);
            chk("rom_en", {15'h0, i != 0}, boot_rom_enable_n_q);
            chk("ram_sel", {15'h0, !i[0]}, ram_sel_n_q);
            chk("prom_sel", {15'h0, i[0]}, prom_sel_n_q);
            if (i[0])
                chk("ram_addr", {2'h0, v[13:0]}, ram_addr_q);
            system_memory_read_n <= 1'b1;
            local_rd <= 1'b0;
        end
        io(1'b1, sb, 16'h0);
        chk("select", 16'h0, board_and_chip_select_q);
        rst_n <= 1'b0;
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        repeat (5) @(posedge clk_sys);
        chk("select", 16'h4, board_and_chip_select_q);
        summarize();
    end
endmodule // adapter_io_decode_select_bench
